// >>> hdl/sadc_ctrl.sv
/*
  Sequencer and control registers of a 10/12-bit successive-approximation
  converter: acquisition, trigger, conversion timing, result formatting,
  buffer slot, half-fill and interrupt/DMA step pacing.
  Assumes APB on clock_in, synchronous inputs and an analog front end that
  presents its raw code on sar_data_in by the end of the sync phase.
*/
// Design decisions made here: the address map and the APB interface to the registers.
// Overview of operation
// - Converter on bit enables operation; zero holds converter off.
// - Stop-when-idle halts the converter while the device is idle.
// - Layout bit picks linear buffer or channel-indexed addressing; needs extended DMA.
// - Extended DMA enable turns on extended DMA and buffer features.
// - Resolution bit picks 12-bit conversion when set, 10-bit otherwise.
// - Result layout picks signed/unsigned, left/right justified output.
// - Trigger source picks software, external, timers, charge unit or automatic end.
// - Auto restart sets the acquire bit right after each conversion.
// - Acquire bit reads one while sampling; software and hardware change it.
// - Finished flag sets on completion, zero while running, software clears.
// - Positive reference field selects external reference or analog supply.
// - Negative reference bit selects external reference or analog ground.
// - Channel-aligned results store by channel; otherwise buffer is a FIFO.
// - Scan enable scans the positive input for the first sample set.
// - Half-fill shows which half of the built-in buffer is filling.
// - In extended buffer mode half-fill shows which destination half fills.
// - Indirect DMA mode steps the address every Nth conversion.
// - Extended buffer mode resets the DMA offset every Nth conversion.
// - Without extended DMA the interrupt fires every Nth conversion.
// - Conversion takes 12 periods at 10 bits, 14 at 12 bits.
// - Each conversion adds a synchronisation delay of 1.5 to 2.5 periods.
// - Conversion period is an integer multiple of the instruction cycle.
// - Divider value plus one gives the period in instruction cycles.
// - Auto acquire time sets automatic sampling length, 0 to 31 periods.
// - Split fill alternates start at slot zero and slot thirteen per interrupt.
// - Alternating select swaps first and second inputs on successive samples.
`timescale 1ns/1ps
module sadc_ctrl
  import sadc_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        resetn_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        idle_mode_in,
  input  wire logic        sleep_mode_in,
  input  wire logic        trig_ext0_in,
  input  wire logic        trig_timer3_in,
  input  wire logic        trig_charge_in,
  input  wire logic        trig_timer1_in,
  input  wire logic [4:0]  channel_in,
  input  wire logic [11:0] sar_data_in,
  output logic             sampling_out,
  output logic             converting_out,
  output logic [15:0]      result_out,
  output logic [4:0]       result_slot_out,
  output logic             result_valid_out,
  output logic             conv_irq_out,
  output logic             dma_step_out,
  output logic             dma_offset_reset_out,
  output logic [1:0]       pos_ref_select_out,
  output logic             neg_ref_select_out,
  output logic             scan_enable_out,
  output logic             sample_b_select_out
);
  // Result layout: left-justify first, derive both signed forms from it; unsigned right form comes from raw
  function automatic logic [15:0] fmt(input logic [11:0] raw, input logic res12, input logic [1:0] form);
    logic [15:0] lj;
    logic [15:0] sf;
    lj = res12 ? {raw, 4'h0} : {raw[9:0], 6'h00};
    sf = {~lj[15], lj[14:0]};
    unique case (form)
      2'h3:    fmt = sf;
      2'h2:    fmt = lj;
      2'h1:    fmt = res12 ? 16'($signed(sf) >>> 4) : 16'($signed(sf) >>> 6);
      default: fmt = res12 ? {4'h0, raw} : {6'h00, raw[9:0]};
    endcase
  endfunction : fmt

  logic [15:0] ctrl_one;
  logic [15:0] ctrl_two;
  logic [15:0] ctrl_three;
  sadc_state_e state;
  sadc_state_e next_state;
  logic [7:0]  tad_cnt;
  logic [4:0]  ph_cnt;
  logic [4:0]  sample_cnt;
  logic [4:0]  fill_base;
  logic        alt_b;

  // Field views
  wire         f_on     = ctrl_one[B_ON];
  wire         f_xdma   = ctrl_one[B_XDMA];
  wire         f_lin    = ctrl_one[B_LAYOUT] & f_xdma; // layout only counts with extended DMA
  wire         f_res12  = ctrl_one[B_RES12];
  wire [1:0]   f_form   = ctrl_one[B_FORM+:2];
  wire [3:0]   f_trig   = ctrl_one[B_TRIG+:4];
  wire         f_auto_acquire_restart   = ctrl_one[B_AUTO_ACQUIRE_RESTART];
  wire         f_acq    = ctrl_one[B_ACQ];
  wire         f_done   = ctrl_one[B_DONE];
  wire [4:0]   f_inc    = ctrl_two[B_INC+:5];
  wire [4:0]   f_samc   = ctrl_three[B_SAMC+:5];
  wire [7:0]   f_div    = ctrl_three[B_DIV+:8];

  // Bus decode; the slave answers one cycle after setup
  wire         setup    = psel_in & ~penable_in;
  wire         wr_go    = psel_in & penable_in & pready_out & pwrite_in;
  wire         hit_one  = paddr_in == OFS_CTRL_ONE;
  wire         hit_two  = paddr_in == OFS_CTRL_TWO;
  wire         hit_thr  = paddr_in == OFS_CTRL_THREE;
  wire         unmapped = ~(hit_one | hit_two | hit_thr);
  wire         wr_one   = wr_go & hit_one;
  wire [15:0]  wdat     = pwdata_in[15:0];
  wire         half_now = f_lin ? (sample_cnt >= 5'((f_inc + 5'h01) >> 1))
                                : (fill_base == SPLIT_BASE);
  wire [15:0]  rd_two   = {ctrl_two[15:8], half_now, ctrl_two[6:0]};
  wire [15:0]  rd_mux   = hit_one ? ctrl_one : hit_two ? rd_two : hit_thr ? ctrl_three : 16'h0000;

  // Sequencing conditions
  wire         running  = f_on & ~(idle_mode_in & ctrl_one[B_SIDL]);
  wire [4:0]   sar_len  = f_res12 ? SAR_TAD_12 : SAR_TAD_10;
  wire         tad_tick = tad_cnt == f_div;
  wire         auto_end = ph_cnt == f_samc;
  wire         trig_hit = (f_trig == TRG_EXT0   & trig_ext0_in)
                        | (f_trig == TRG_TMR3   & trig_timer3_in)
                        | (f_trig == TRG_CTU    & trig_charge_in)
                        | (f_trig == TRG_TMR1   & trig_timer1_in & ~sleep_mode_in)
                        | (f_trig == TRG_TMR1_S & trig_timer1_in)
                        | (f_trig == TRG_AUTO   & auto_end);
  wire         in_acq   = state == ST_ACQ;
  wire         conv_go  = in_acq & running & (f_trig == TRG_SOFT ? ~f_acq : trig_hit);
  wire         complete = state == ST_SYNC & running & tad_tick & ph_cnt == SYNC_TAD - 5'h01;
  wire         group    = complete & sample_cnt == f_inc;
  wire [4:0]   slot     = ctrl_two[B_ALIGN] ? channel_in : 5'(fill_base + sample_cnt);

  // Next state of the acquire, convert, sync sequence
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (running & f_acq) next_state = ST_ACQ;
      ST_ACQ: begin
        if (!running) next_state = ST_IDLE;
        else if (conv_go) next_state = ST_CONV;
        else if (!f_acq) next_state = ST_IDLE;
      end
      ST_CONV: begin
        if (!running) next_state = ST_IDLE;
        else if (tad_tick && ph_cnt == sar_len - 5'h01) next_state = ST_SYNC;
      end
      ST_SYNC: begin
        if (!running) next_state = ST_IDLE;
        else if (complete) next_state = f_auto_acquire_restart ? ST_ACQ : ST_IDLE;
      end
    endcase
  end

  // Bus answer registers
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= setup;
      pslverr_out <= setup & unmapped;
      if (setup && !pwrite_in) prdata_out <= {16'h0000, rd_mux};
    end
  end

  // Control registers; hardware set of acquire and finished wins over clear
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      ctrl_one   <= RST_CTRL;
      ctrl_two   <= RST_CTRL;
      ctrl_three <= RST_CTRL;
    end else begin
      if (wr_one) ctrl_one[15:1] <= wdat[15:1] & WMASK_ONE[15:1];
      if (wr_one && !wdat[B_DONE]) ctrl_one[B_DONE] <= 1'b0;       // clear only
      if (wr_go && hit_two) ctrl_two <= wdat & WMASK_TWO;
      if (wr_go && hit_thr) ctrl_three <= wdat & WMASK_THREE;
      if (conv_go) ctrl_one[B_ACQ] <= 1'b0;                         // hold starts
      if (conv_go) ctrl_one[B_DONE] <= 1'b0;
      if (complete && f_auto_acquire_restart) ctrl_one[B_ACQ] <= 1'b1;
      if (complete) ctrl_one[B_DONE] <= 1'b1;
    end
  end

  // Period divider and phase counter restart on every phase change
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      state   <= ST_IDLE;
      tad_cnt <= 8'h00;
      ph_cnt  <= 5'h00;
    end else begin
      state   <= next_state;
      tad_cnt <= (next_state != state || tad_tick) ? 8'h00 : tad_cnt + 8'h01;
      if (next_state != state) ph_cnt <= 5'h00;
      else if (tad_tick && ph_cnt != 5'h1F) ph_cnt <= ph_cnt + 5'h01;
    end
  end

  // Sample grouping, fill half and alternate input tracking
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      sample_cnt <= 5'h00;
      fill_base  <= 5'h00;
      alt_b      <= 1'b0;
    end else begin
      if (group) sample_cnt <= 5'h00;
      else if (complete) sample_cnt <= sample_cnt + 5'h01;
      if (!ctrl_two[B_SPLIT] || f_xdma) fill_base <= 5'h00;
      else if (group) fill_base <= (fill_base == 5'h00) ? SPLIT_BASE : 5'h00;
      if (!ctrl_two[B_ALTERNATING_INPUT_SELECT]) alt_b <= 1'b0;
      else if (complete) alt_b <= ~alt_b;
    end
  end

  // Result and pacing outputs, all registered
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      result_out           <= 16'h0000;
      result_slot_out      <= 5'h00;
      result_valid_out     <= 1'b0;
      conv_irq_out         <= 1'b0;
      dma_step_out         <= 1'b0;
      dma_offset_reset_out <= 1'b0;
    end else begin
      result_valid_out     <= complete;
      conv_irq_out         <= group & ~f_xdma;
      dma_step_out         <= group & f_xdma & ~f_lin;
      dma_offset_reset_out <= group & f_lin;
      if (complete) begin
        result_out      <= fmt(sar_data_in, f_res12, f_form);
        result_slot_out <= slot;
      end
    end
  end

  // Front-end steering
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      sampling_out        <= 1'b0;
      converting_out      <= 1'b0;
      pos_ref_select_out  <= 2'h0;
      neg_ref_select_out  <= 1'b0;
      scan_enable_out     <= 1'b0;
      sample_b_select_out <= 1'b0;
    end else begin
      sampling_out        <= next_state == ST_ACQ;
      converting_out      <= next_state == ST_CONV;
      pos_ref_select_out  <= ctrl_two[B_PREF+:2];
      neg_ref_select_out  <= ctrl_two[B_NREF];
      scan_enable_out     <= ctrl_two[B_SCAN] & ~alt_b;
      sample_b_select_out <= alt_b;
    end
  end

  // Checks: helper counts clock cycles spent converting
  logic [12:0] conv_cyc;
  always_ff @(posedge clock_in) begin
    if (!resetn_in) conv_cyc <= 13'h0000;
    else conv_cyc <= (state == ST_CONV) ? conv_cyc + 13'h0001 : 13'h0000;
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  done_set_a: assert property (complete |=> f_done && result_valid_out)
    else $error("finished flag not set after completion");
  conv_clear_a: assert property (state == ST_CONV |-> !f_done)
    else $error("finished flag high during conversion");
  power_off_a: assert property (!f_on |=> state == ST_IDLE)
    else $error("sequencer active while converter is off");
  idle_stop_a: assert property (f_on && idle_mode_in && ctrl_one[B_SIDL] |=> state == ST_IDLE)
    else $error("sequencer active in idle with stop bit set");
  sar_len_a: assert property (state == ST_CONV && next_state == ST_SYNC
      |-> 32'(conv_cyc) + 1 == 32'(sar_len) * (32'(f_div) + 1))
    else $error("conversion phase length wrong");
  auto_restart_a: assert property (complete && f_auto_acquire_restart |=> f_acq && sampling_out)
    else $error("acquisition not restarted");
  irq_rate_a: assert property (conv_irq_out |-> $past(sample_cnt) == f_inc && !f_xdma)
    else $error("interrupt at wrong sample count");
  format_a: assert property (result_valid_out && f_form == 2'h0 && !f_res12
      |-> result_out[15:10] == 6'h00)
    else $error("unsigned 10-bit result not right justified");
  trig_hold_a: assert property (conv_go |=> !f_acq && state == ST_CONV)
    else $error("trigger did not end acquisition");

  cov_auto: cover property (f_trig == TRG_AUTO && complete);
  cov_group: cover property (group && f_lin);
  cov_split: cover property (group && fill_base == SPLIT_BASE);
endmodule : sadc_ctrl

// >>> hdl/sadc_pkg.sv
/*
  Shared constants for the converter sequencer control block: register
  offsets, field positions, reset values and timing counts.
  Assumes an APB slave with 32-bit data, one 16-bit register per word.
*/
package sadc_pkg;
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL_ONE   = 12'h000;
  localparam logic [11:0] OFS_CTRL_TWO   = 12'h004;
  localparam logic [11:0] OFS_CTRL_THREE = 12'h008;
  // Control register one fields
  localparam int B_ON      = 15;
  localparam int B_SIDL    = 13;
  localparam int B_LAYOUT  = 12;
  localparam int B_XDMA    = 11;
  localparam int B_RES12   = 10;
  localparam int B_FORM    = 8;
  localparam int B_TRIG    = 4;
  localparam int B_AUTO_ACQUIRE_RESTART    = 2;
  localparam int B_ACQ     = 1;
  localparam int B_DONE    = 0;
  // Control register two fields
  localparam int B_PREF    = 14;
  localparam int B_NREF    = 13;
  localparam int B_ALIGN   = 11;
  localparam int B_SCAN    = 10;
  localparam int B_HALF    = 7;
  localparam int B_INC     = 2;
  localparam int B_SPLIT   = 1;
  localparam int B_ALTERNATING_INPUT_SELECT    = 0;
  // Control register three fields
  localparam int B_SAMC    = 8;
  localparam int B_DIV     = 0;
  // Writable masks and reset values
  localparam logic [15:0] WMASK_ONE   = 16'hBFF7;
  localparam logic [15:0] WMASK_TWO   = 16'hEC7F;
  localparam logic [15:0] WMASK_THREE = 16'h1FFF;
  localparam logic [15:0] RST_CTRL    = 16'h0000;
  // Trigger source codes
  localparam logic [3:0] TRG_SOFT   = 4'h0;
  localparam logic [3:0] TRG_EXT0   = 4'h1;
  localparam logic [3:0] TRG_TMR3   = 4'h2;
  localparam logic [3:0] TRG_CTU    = 4'h4;
  localparam logic [3:0] TRG_TMR1   = 4'h5;
  localparam logic [3:0] TRG_TMR1_S = 4'h6;
  localparam logic [3:0] TRG_AUTO   = 4'h7;
  // Timing in conversion-clock periods, and the split fill base slot
  localparam logic [4:0] SAR_TAD_10 = 5'h0C;
  localparam logic [4:0] SAR_TAD_12 = 5'h0E;
  localparam logic [4:0] SYNC_TAD   = 5'h02;
  localparam logic [4:0] SPLIT_BASE = 5'h0D;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ACQ  = 4'b0010,
    ST_CONV = 4'b0100,
    ST_SYNC = 4'b1000
  } sadc_state_e;
endpackage : sadc_pkg

// >>> dv/sadc_front_model.sv
/*
  Behavioural far side of the converter: analog front end and trigger sources.
  Assumes the bench sets raw_in before each conversion and pulses trig_go_in once.
*/
`timescale 1ns/1ps
module sadc_front_model
  import sadc_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        converting_in,
  input  wire logic        result_valid_in,
  input  wire logic        trig_go_in,
  input  wire logic [3:0]  trig_code_in,
  input  wire logic [11:0] raw_in,
  output logic      [11:0] sar_data_out,
  output logic      [4:0]  channel_out,
  output logic             ext0_out,
  output logic             timer3_out,
  output logic             charge_out,
  output logic             timer1_out
);
  logic held = 1'b0;
  initial channel_out = 5'h00;
  // Code is held from conversion start until the result is taken, then inverted
  always @(posedge clock_in) begin
    if (converting_in) held <= 1'b1;
    else if (result_valid_in) begin
      held        <= 1'b0;
      channel_out <= (channel_out == 5'd25) ? 5'h00 : channel_out + 5'h01;
    end
  end
  // Released code is inverted so a late sample never matches by luck
  assign sar_data_out = held ? raw_in : ~raw_in;
  // One event line per source, timer1 shared by both timer codes; high for the single cycle of go
  assign ext0_out   = trig_go_in && trig_code_in == TRG_EXT0;
  assign timer3_out = trig_go_in && trig_code_in == TRG_TMR3;
  assign charge_out = trig_go_in && trig_code_in == TRG_CTU;
  assign timer1_out = trig_go_in && (trig_code_in == TRG_TMR1 || trig_code_in == TRG_TMR1_S);
endmodule : sadc_front_model

// >>> dv/sadc_ctrl_tb.sv
/*
  Self-checking bench for the converter sequencer: registers over APB,
  timing, result layout, triggers, group pacing, off and idle stop.
  Assumes the front model answers for the analog side.
*/
`timescale 1ns/1ps
module sadc_ctrl_tb;
  import sadc_pkg::*;
  localparam int ON = 1 << B_ON;
  localparam int ACQ = 1 << B_ACQ;
  localparam int AUTO = TRG_AUTO << B_TRIG;
  logic clock_in, resetn_in, psel, pen, pwr, idle, sleep, go, rv, cv, acquire_control, irq, stp, orst, rdy, err, e;
  logic [11:0] paddr, sar, raw;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] res;
  logic [4:0]  chan;
  logic [3:0]  tcode;
  logic        t0, t1, t2, t3, nref, scan;
  logic [1:0]  pref;
  int n_errors, n_compared, seed, cyc, nr, ni, ns, no, n, tt[2];
  logic [3:0]  codes[5] = '{TRG_EXT0, TRG_TMR3, TRG_CTU, TRG_TMR1, TRG_TMR1_S};
  logic [11:0] ofs[3] = '{OFS_CTRL_ONE, OFS_CTRL_TWO, OFS_CTRL_THREE};

  sadc_ctrl uut (.clock_in(clock_in), .resetn_in(resetn_in), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(rdy),
    .pslverr_out(err), .idle_mode_in(idle), .sleep_mode_in(sleep), .trig_ext0_in(t0),
    .trig_timer3_in(t1), .trig_charge_in(t2), .trig_timer1_in(t3), .channel_in(chan),
    .sar_data_in(sar), .sampling_out(acquire_control), .converting_out(cv), .result_out(res),
    .result_slot_out(), .result_valid_out(rv), .conv_irq_out(irq), .dma_step_out(stp),
    .dma_offset_reset_out(orst), .pos_ref_select_out(pref), .neg_ref_select_out(nref),
    .scan_enable_out(scan), .sample_b_select_out());
  sadc_front_model far (.clock_in(clock_in), .converting_in(cv), .result_valid_in(rv),
    .trig_go_in(go), .trig_code_in(tcode), .raw_in(raw), .sar_data_out(sar), .channel_out(chan),
    .ext0_out(t0), .timer3_out(t1), .charge_out(t2), .timer1_out(t3));

  // Clock at 200 MHz
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  // Pulse counters on the falling edge, where outputs have settled
  always @(negedge clock_in) begin
    nr += rv;
    ni += irq;
    ns += stp;
    no += orst;
  end
  // Hang guard: far above the fewer than two thousand cycles the run needs
  always @(posedge clock_in) begin
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One APB transfer; waits for pready, then releases and lets an edge pass
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clock_in);
      k++;
    end while (rdy !== 1'b1 && k < 50);
    r = prdata;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clock_in);
  endtask : apb
  task automatic wr(input logic [11:0] a, input int d);
    apb(1'b1, a, d);
  endtask : wr
  // Cycles until a result appears, or -1 past the limit
  task automatic wres(input int lim, output int c);
    c = 0;
    while (rv !== 1'b1 && c < lim) begin
      @(posedge clock_in);
      c++;
    end
    if (c >= lim) c = -1;
    else @(posedge clock_in);
  endtask : wres
  task automatic run(input int c1, output int c);
    wr(OFS_CTRL_ONE, c1);
    wr(OFS_CTRL_ONE, c1 | ACQ);
    wres(200, c);
  endtask : run
  // Reference layout: offset binary to two's complement, then justify
  function automatic logic [15:0] fmt(int rw, int r12, int f);
    int w, v;
    w = r12 ? 12 : 10;
    v = rw % (1 << w);
    if (f % 2) v = v - (1 << (w - 1));
    if (f / 2) v = v << (16 - w);
    return v[15:0];
  endfunction : fmt
  task automatic wrap_up();
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  initial begin
    {resetn_in, psel, pen, pwr, idle, sleep, go} = '0;
    {paddr, pwdata, tcode, raw} = '0;
    seed = 29246;
    repeat (4) @(posedge clock_in);
    resetn_in <= 1'b1;
    @(posedge clock_in);
    foreach (ofs[i]) begin
      apb(1'b0, ofs[i], 0);
      chk("reset value", r, 0);
    end
    apb(1'b0, 12'h00C, 0);
    chk("unmapped err", e, 1);
    chk("unmapped data", r, 0);
    wr(OFS_CTRL_TWO, 32'h0000_7FFF);
    apb(1'b0, OFS_CTRL_TWO, 0);
    chk("ctrl two rw", r, 32'h0000_6C7F);
    chk("pos ref", pref, 1);
    chk("neg ref", nref, 1);
    chk("scan enable", scan, 1);
    wr(OFS_CTRL_TWO, 0);
    // Every resolution and layout with a random code
    for (int q = 0; q < 2; q++) begin
      for (int f = 0; f < 4; f++) begin
        raw <= $random(seed);
        run(ON | AUTO | (q << B_RES12) | (f << B_FORM), n);
        chk("result", res, fmt(raw, q, f));
        apb(1'b0, OFS_CTRL_ONE, 0);
        chk("done acq", r[1:0], 2'b01);
        if (f == 0) tt[q] = n;
      end
    end
    chk("res12 time", tt[1] - tt[0], 2);
    wr(OFS_CTRL_THREE, 1);
    run(ON | AUTO, n);
    chk("divider time", n - tt[0], 14);
    wr(OFS_CTRL_THREE, 3 << B_SAMC);
    run(ON | AUTO, n);
    chk("acquire time", n - tt[0], 3);
    wr(OFS_CTRL_THREE, 0);
    // Software end of acquisition
    run(ON, n);
    chk("held", n, -1);
    chk("sampling", acquire_control, 1);
    wr(OFS_CTRL_ONE, ON);
    wres(100, n);
    chk("soft conv", n < 0, 0);
    // Event triggers; plain timer code must stay quiet in sleep
    foreach (codes[i]) begin
      tcode <= codes[i];
      sleep <= codes[i] inside {TRG_TMR1, TRG_TMR1_S};
      wr(OFS_CTRL_ONE, ON | (codes[i] << B_TRIG));
      wr(OFS_CTRL_ONE, ON | ACQ | (codes[i] << B_TRIG));
      go <= 1'b1;
      @(posedge clock_in);
      go <= 1'b0;
      wres(100, n);
      chk("trigger", n < 0, codes[i] == TRG_TMR1);
    end
    sleep <= 1'b0;
    // Pacing every second result in the three buffer modes, then switch off
    for (int m = 0; m < 3; m++) begin
      wr(OFS_CTRL_ONE, 0);
      wr(OFS_CTRL_TWO, 1 << B_INC);
      {nr, ni, ns, no} = '0;
      run(ON | AUTO | (1 << B_AUTO_ACQUIRE_RESTART) | ((m > 0) << B_XDMA) | ((m == 2) << B_LAYOUT), n);
      repeat (3) wres(200, n);
      wr(OFS_CTRL_ONE, 0);
      repeat (40) @(posedge clock_in);
      chk("results", nr, 4);
      chk("irq", ni, m == 0 ? 2 : 0);
      chk("dma step", ns, m == 1 ? 2 : 0);
      chk("offset reset", no, m == 2 ? 2 : 0);
    end
    // Idle with and without stop
    idle <= 1'b1;
    run(ON | AUTO | (1 << B_SIDL), n);
    chk("idle stop", n, -1);
    wr(OFS_CTRL_ONE, 0);
    run(ON | AUTO, n);
    chk("idle run", n < 0, 0);
    wrap_up();
  end
endmodule : sadc_ctrl_tb
